// File: logic/ddc_pkg.sv
// Shared constants, types and helpers for the DRAM command link
package ddc_pkg;
  localparam int DQ_W   = 4;
  localparam int BA_W   = 3;
  localparam int ADDR_W = 14;
  localparam int NBANK  = 8;
  localparam int NMR    = 4;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int MR1_TDQS_BIT = 11;
  localparam int MR1_RTT0 = 2;
  localparam int MR1_RTT1 = 6;
  localparam int MR1_RTT2 = 9;
  localparam int WR_LAT = 5;
  localparam int RD_LAT = 6;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] LEN_BL8 = 4'h8;
  localparam logic [3:0] LEN_BC4 = 4'h4;
  localparam logic [13:0] MR_RST = 14'h0000;
  localparam logic [1:0] BLM_FIX8 = 2'h0;
  localparam logic [1:0] BLM_OTF  = 2'h1;
  localparam logic [1:0] BLM_FIX4 = 2'h2;

  // Command code carried by RAS#, CAS#, WE# while CS# is low
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000, CMD_REF = 3'b001, CMD_PRE = 3'b010,
    CMD_ACT = 3'b011, CMD_WR  = 3'b100, CMD_RD  = 3'b101,
    CMD_ZQC = 3'b110, CMD_NOP = 3'b111
  } ddc_cmd_t;

  typedef enum logic [1:0] {
    PWR_NORM = 2'b00, PWR_APD = 2'b01, PWR_PPD = 2'b10, PWR_SREF = 2'b11
  } ddc_pwr_t;

  // Beats of a burst from the burst field of MR0 and address bit 12
  function automatic logic [3:0] burst_len(input logic [13:0] mr0,
                                           input logic        a12);
    case (mr0[1:0])
      BLM_OTF:  burst_len = a12 ? LEN_BL8 : LEN_BC4;
      BLM_FIX4: burst_len = LEN_BC4;
      default:  burst_len = LEN_BL8;
    endcase
  endfunction

  // Termination selected at all in MR1
  function automatic logic rtt_on(input logic [13:0] mr1);
    rtt_on = mr1[MR1_RTT0] | mr1[MR1_RTT1] | mr1[MR1_RTT2];
  endfunction
endpackage

// File: logic/ddc_link_if.sv
// Pin-level link between controller end and DRAM end
`timescale 1ns/1ns
`default_nettype none
interface ddc_link_if;
  logic                       reset_n;
  logic                       cke;
  logic                       cs_n;
  logic                       ras_n;
  logic                       cas_n;
  logic                       we_n;
  logic [ddc_pkg::BA_W-1:0]   ba;
  logic [ddc_pkg::ADDR_W-1:0] addr;
  logic                       odt;
  logic                       dm;
  logic                       tdqs;
  logic [ddc_pkg::DQ_W-1:0]   dq_h_o;
  logic                       dq_h_oe;
  logic [ddc_pkg::DQ_W-1:0]   dq_d_o;
  logic                       dq_d_oe;
  logic                       dqs_h_o;
  logic                       dqs_h_oe;
  logic                       dqs_d_o;
  logic                       dqs_d_oe;
  logic [ddc_pkg::DQ_W-1:0]   dq;
  logic                       dqs;

  // Resolved wire levels; an undriven bus reads as zero
  assign dq  = dq_h_oe ? dq_h_o : (dq_d_oe ? dq_d_o : '0);
  assign dqs = dqs_h_oe ? dqs_h_o : (dqs_d_oe ? dqs_d_o : 1'b0);

  modport ctrl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                odt, dm, dq_h_o, dq_h_oe, dqs_h_o, dqs_h_oe,
                input tdqs, dq, dqs, dq_d_oe, dqs_d_oe);
  modport dram (input reset_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                odt, dm, dq, dqs, dq_h_oe,
                output tdqs, dq_d_o, dq_d_oe, dqs_d_o, dqs_d_oe);
endinterface
`default_nettype wire

// File: logic/ddc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ddc_fifo #(
  parameter int W     = 5,
  parameter int DEPTH = 16
) (
  input  wire logic                   clk,       // Clock
  input  wire logic                   rst,       // Async reset
  input  wire logic                   in_valid,  // Write offered
  output logic                        in_ready,  // Space free
  input  wire logic [W-1:0]           in_data,   // Write word
  output logic                        out_valid, // Word held
  input  wire logic                   out_ready, // Drain
  output logic [W-1:0]                out_data,  // Head word
  output logic [$clog2(DEPTH+1)-1:0]  level      // Words held
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [LW-1:0] lv_r, lv_nxt;
  logic          push, pop;

  assign in_ready  = (lv_r != LW'(DEPTH));
  assign out_valid = (lv_r != '0);
  assign out_data  = mem[rp_r];
  assign level     = lv_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wp_nxt = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
    lv_nxt = lv_r + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      lv_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      lv_r <= lv_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: logic/ddc_dram_end.sv
// DRAM end: command decode, banks, mode registers, power, data array
// Contract
// (RL1) ACT carries row; READ/WRITE column plus A10
// (RL2) PRECHARGE: A10 low one bank, high all
// (RL3) LOAD MODE op-code on address, device stores it
// (RL4) On-the-fly chop: A12 high BL8, low BC4
// (RL5) Bank inputs pick target bank of command
// (RL6) Bank inputs pick mode register zero to three
// (RL7) Inputs sampled on rising true clock
// (RL8) CKE low enters power-down or self refresh
// (RL9) CKE synchronous, except self-refresh exit
// (RL10) Low-power states disable most input buffers
// (RL11) CS# high masks every command
// (RL12) CS#, RAS#, CAS#, WE# encode command together
// (RL13) DM high masks that write beat
// (RL14) x8 DM may serve as termination strobe
// (RL15) ODT high enables termination on data pins
// (RL16) ODT ignored when termination disabled by mode
// (RL17) RESET# acts asynchronously both ways
// (RL18) x4 data over four bidirectional lines
// (RL19) Termination strobe enabled disables data mask
// (RL20) DQS edge-aligned on read, centred on write; here DQS is held high for the whole burst both ways
`timescale 1ns/1ns
`default_nettype none
module ddc_dram_end #(
  parameter int ROW_AW = 2,
  parameter int COL_AW = 4
) (
  ddc_link_if.dram         lk,        // Link pins
  input  wire logic        clk,       // Clock, rising edge = CK crossing
  input  wire logic        rst,       // Async reset
  output logic [1:0]       pwr_state, // Power state
  output logic [7:0]       bank_open, // Banks with an open row
  output logic             term_en,   // Termination applied
  output logic             tdqs_en,   // Termination strobe mode
  output logic             busy       // Burst in progress
);
  localparam int MAW = ddc_pkg::BA_W + ROW_AW + COL_AW;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WLAT = 3'b001, ST_WBURST = 3'b010,
    ST_RLAT = 3'b011, ST_RBURST = 3'b100
  } ddc_st_t;

  logic [ddc_pkg::DQ_W-1:0] mem [2**MAW];
  ddc_st_t                  st_r, st_nxt;
  ddc_pkg::ddc_pwr_t        pwr_r, pwr_nxt;
  logic [2:0]               cnt_r, cnt_nxt;
  logic [2:0]               beat_r, beat_nxt;
  logic [2:0]               last_r, last_nxt;
  logic [2:0]               bank_r, bank_nxt;
  logic [ROW_AW-1:0]        row_r, row_nxt;
  logic [COL_AW-1:0]        col_r, col_nxt;
  logic [7:0]               open_r, open_nxt;
  logic [ROW_AW-1:0]        rows_r [8];
  logic [ROW_AW-1:0]        rows_nxt [8];
  logic [13:0]              mr_r [4];
  logic [13:0]              mr_nxt [4];
  logic                     cke_q_r, term_r, term_nxt;
  logic [ddc_pkg::DQ_W-1:0] rdq_r, rdq_nxt;
  logic                     roe_r, roe_nxt;
  logic                     wr_en;
  logic [MAW-1:0]           wr_ix;
  logic                     cmd_en, all_idle, tdqs_on;
  ddc_pkg::ddc_cmd_t        cmd;
  logic [3:0]               blen;

  function automatic logic [MAW-1:0] ix(input logic [2:0]        b,
                                        input logic [ROW_AW-1:0] r,
                                        input logic [COL_AW-1:0] c,
                                        input logic [2:0]        beat);
    ix = {b, r, c + COL_AW'(beat)};
  endfunction

  assign cmd      = ddc_pkg::ddc_cmd_t'({lk.ras_n, lk.cas_n, lk.we_n}); // RL12
  assign all_idle = (open_r == 8'h00);
  assign tdqs_on  = mr_r[1][ddc_pkg::MR1_TDQS_BIT];
  assign blen     = ddc_pkg::burst_len(mr_r[0], lk.addr[ddc_pkg::BC_BIT]);
  // Decoder live only in normal power with CKE held and CS# low
  assign cmd_en   = (pwr_r == ddc_pkg::PWR_NORM) & cke_q_r & lk.cke
                  & ~lk.cs_n; // RL11 RL10

  assign pwr_state   = pwr_r;
  assign bank_open   = open_r;
  assign term_en     = term_r;
  assign tdqs_en     = tdqs_on;
  assign busy        = (st_r != ST_IDLE);
  assign lk.dq_d_o   = rdq_r; // RL18
  assign lk.dq_d_oe  = roe_r;
  assign lk.dqs_d_o  = roe_r; // RL20
  assign lk.dqs_d_oe = roe_r; // RL20
  assign lk.tdqs     = tdqs_on & term_r; // RL14

  always_comb begin
    st_nxt   = st_r;
    pwr_nxt  = pwr_r;
    cnt_nxt  = cnt_r;
    beat_nxt = beat_r;
    last_nxt = last_r;
    bank_nxt = bank_r;
    row_nxt  = row_r;
    col_nxt  = col_r;
    open_nxt = open_r;
    rows_nxt = rows_r;
    mr_nxt   = mr_r;
    rdq_nxt  = rdq_r;
    roe_nxt  = roe_r;
    wr_en    = 1'b0;
    wr_ix    = ix(bank_r, row_r, col_r, beat_r);
    // Power state from CKE edges
    case (pwr_r)
      ddc_pkg::PWR_NORM: begin
        if (cke_q_r && !lk.cke) begin // RL8 RL9
          if (!lk.cs_n && cmd == ddc_pkg::CMD_REF && all_idle) begin
            pwr_nxt = ddc_pkg::PWR_SREF;
          end else if (all_idle) begin
            pwr_nxt = ddc_pkg::PWR_PPD;
          end else begin
            pwr_nxt = ddc_pkg::PWR_APD;
          end
        end
      end
      ddc_pkg::PWR_SREF: begin
        // Exit on any sight of CKE high, no prior sample needed
        if (lk.cke) begin // RL9
          pwr_nxt = ddc_pkg::PWR_NORM;
        end
      end
      default: begin
        if (lk.cke) begin // RL8 RL9
          pwr_nxt = ddc_pkg::PWR_NORM;
        end
      end
    endcase
    // Termination: ODT level, gated by mode and self refresh
    term_nxt = lk.odt & ddc_pkg::rtt_on(mr_r[1])
             & (pwr_nxt != ddc_pkg::PWR_SREF); // RL15 RL16 RL10
    // Command decode
    if (cmd_en) begin
      case (cmd)
        ddc_pkg::CMD_ACT: begin
          open_nxt[lk.ba] = 1'b1; // RL5
          rows_nxt[lk.ba] = lk.addr[ROW_AW-1:0]; // RL1
        end
        ddc_pkg::CMD_PRE: begin
          if (lk.addr[ddc_pkg::AP_BIT]) begin // RL2
            open_nxt = 8'h00;
          end else begin
            open_nxt[lk.ba] = 1'b0; // RL2 RL5
          end
        end
        ddc_pkg::CMD_MRS: begin
          if (all_idle && !lk.ba[2]) begin
            mr_nxt[lk.ba[1:0]] = lk.addr; // RL3 RL6
          end
        end
        ddc_pkg::CMD_RD, ddc_pkg::CMD_WR: begin
          if (open_r[lk.ba] && st_r == ST_IDLE) begin
            bank_nxt = lk.ba; // RL5
            row_nxt  = rows_r[lk.ba];
            col_nxt  = lk.addr[COL_AW-1:0]; // RL1
            last_nxt = 3'(blen - 4'h1); // RL4
            cnt_nxt  = (cmd == ddc_pkg::CMD_WR) ? 3'(ddc_pkg::WR_LAT - 1)
                                                : 3'(ddc_pkg::RD_LAT - 1);
            st_nxt   = (cmd == ddc_pkg::CMD_WR) ? ST_WLAT : ST_RLAT;
            if (lk.addr[ddc_pkg::AP_BIT]) begin // RL1
              open_nxt[lk.ba] = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // Data bursts
    case (st_r)
      ST_WLAT, ST_RLAT: begin
        if (cnt_r == 3'h0) begin
          beat_nxt = 3'h0;
          st_nxt   = (st_r == ST_WLAT) ? ST_WBURST : ST_RBURST;
          if (st_r == ST_RLAT) begin
            roe_nxt = 1'b1;
            rdq_nxt = mem[ix(bank_r, row_r, col_r, 3'h0)];
          end
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      ST_WBURST: begin
        wr_en = ~(lk.dm & ~tdqs_on); // RL13 RL19
        if (beat_r == last_r) begin
          st_nxt = ST_IDLE;
        end else begin
          beat_nxt = beat_r + 3'h1;
        end
      end
      // Idle must keep a burst start chosen by the decoder above
      ST_IDLE: begin
      end
      ST_RBURST: begin
        if (beat_r == last_r) begin
          st_nxt  = ST_IDLE;
          roe_nxt = 1'b0;
        end else begin
          beat_nxt = beat_r + 3'h1;
          rdq_nxt  = mem[ix(bank_r, row_r, col_r, beat_r + 3'h1)];
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // State registers; RESET# clears without the clock
  always_ff @(posedge clk or posedge rst or negedge lk.reset_n) begin // RL7
    if (rst || !lk.reset_n) begin // RL17
      st_r    <= ST_IDLE;
      pwr_r   <= ddc_pkg::PWR_NORM;
      cnt_r   <= '0;
      beat_r  <= '0;
      last_r  <= '0;
      bank_r  <= '0;
      row_r   <= '0;
      col_r   <= '0;
      open_r  <= '0;
      rows_r  <= '{default: '0};
      mr_r    <= '{default: ddc_pkg::MR_RST};
      cke_q_r <= 1'b0;
      term_r  <= 1'b0;
      rdq_r   <= '0;
      roe_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      pwr_r   <= pwr_nxt;
      cnt_r   <= cnt_nxt;
      beat_r  <= beat_nxt;
      last_r  <= last_nxt;
      bank_r  <= bank_nxt;
      row_r   <= row_nxt;
      col_r   <= col_nxt;
      open_r  <= open_nxt;
      rows_r  <= rows_nxt;
      mr_r    <= mr_nxt;
      cke_q_r <= lk.cke;
      term_r  <= term_nxt;
      rdq_r   <= rdq_nxt;
      roe_r   <= roe_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_ix] <= lk.dq; // RL13 RL18
    end
  end
endmodule
`default_nettype wire

// File: logic/ddc_ctrl_end.sv
// Controller end: issues commands, streams write data, collects reads
`timescale 1ns/1ns
`default_nettype none
module ddc_ctrl_end #(
  parameter int DEPTH = ddc_pkg::FIFO_DEPTH
) (
  ddc_link_if.ctrl                    lk,        // Link pins
  input  wire logic                   clk,       // Clock
  input  wire logic                   rst,       // Async reset
  input  wire logic                   reset_req, // Hold DRAM in reset
  input  wire logic                   cke_req,   // CKE level to drive
  input  wire logic                   odt_req,   // ODT level to drive
  input  wire logic                   cmd_valid, // Command offered
  output logic                        cmd_ready, // Command taken
  input  wire ddc_pkg::ddc_cmd_t      cmd_op,    // Command code
  input  wire logic [2:0]             cmd_bank,  // Bank or MR number
  input  wire logic [13:0]            cmd_addr,  // Row, column or op-code
  input  wire logic                   wr_valid,  // Write beat offered
  output logic                        wr_ready,  // FIFO has room
  input  wire logic [ddc_pkg::DQ_W-1:0] wr_data, // Write beat
  input  wire logic                   wr_mask,   // Mask this beat
  output logic                        rd_valid,  // Read beat pulse
  output logic [ddc_pkg::DQ_W-1:0]    rd_data    // Read beat
);
  localparam int W  = ddc_pkg::DQ_W + 1;
  localparam int LW = $clog2(DEPTH + 1);

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_WLAT = 2'b01, HS_WBURST = 2'b10, HS_RWAIT = 2'b11
  } ddc_hst_t;

  ddc_hst_t                 st_r, st_nxt;
  logic [2:0]               cnt_r, cnt_nxt, beat_r, beat_nxt;
  logic [2:0]               last_r, last_nxt;
  logic [13:0]              mr0_r, mr0_nxt;
  logic                     cs_n_r, cs_n_nxt;
  logic [2:0]               rcw_r, rcw_nxt;
  logic [2:0]               ba_r, ba_nxt;
  logic [13:0]              addr_r, addr_nxt;
  logic [ddc_pkg::DQ_W-1:0] dq_r, dq_nxt;
  logic                     dm_r, dm_nxt, oe_r, oe_nxt;
  logic                     cke_r, odt_r, rstn_r;
  logic                     rdv_r;
  logic [ddc_pkg::DQ_W-1:0] rdd_r;
  logic                     f_valid, f_ready;
  logic [W-1:0]             f_data;
  logic [$clog2(DEPTH+1)-1:0] f_level;
  logic [3:0]               blen;
  logic                     take;

  ddc_fifo #(.W(W), .DEPTH(DEPTH)) u_wfifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   ({wr_mask, wr_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data),
    .level     (f_level)
  );

  assign blen = ddc_pkg::burst_len(mr0_r, cmd_addr[ddc_pkg::BC_BIT]); // RL4
  // Write accepted only once its whole burst is already buffered
  assign cmd_ready = (st_r == HS_IDLE) & cke_r & rstn_r
                   & ((cmd_op != ddc_pkg::CMD_WR)
                      | (f_level >= LW'(blen)));
  assign take    = cmd_valid & cmd_ready;
  assign f_ready = ((st_r == HS_WLAT) & (cnt_r == 3'h0))
                 | ((st_r == HS_WBURST) & (beat_r != last_r));

  assign lk.reset_n  = rstn_r;
  assign lk.cke      = cke_r;
  assign lk.odt      = odt_r;
  assign lk.cs_n     = cs_n_r;
  assign lk.ras_n    = rcw_r[2]; // RL12
  assign lk.cas_n    = rcw_r[1];
  assign lk.we_n     = rcw_r[0];
  assign lk.ba       = ba_r; // RL5 RL6
  assign lk.addr     = addr_r; // RL1 RL3
  assign lk.dm       = dm_r;
  assign lk.dq_h_o   = dq_r; // RL18
  assign lk.dq_h_oe  = oe_r;
  assign lk.dqs_h_o  = oe_r; // RL20
  assign lk.dqs_h_oe = oe_r;
  assign rd_valid    = rdv_r;
  assign rd_data     = rdd_r;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    beat_nxt = beat_r;
    last_nxt = last_r;
    mr0_nxt  = mr0_r;
    cs_n_nxt = 1'b1;
    rcw_nxt  = 3'(ddc_pkg::CMD_NOP);
    ba_nxt   = ba_r;
    addr_nxt = addr_r;
    dq_nxt   = dq_r;
    dm_nxt   = 1'b0;
    oe_nxt   = 1'b0;
    if (take) begin
      cs_n_nxt = 1'b0; // RL11 RL12
      rcw_nxt  = 3'(cmd_op);
      ba_nxt   = cmd_bank;
      addr_nxt = cmd_addr;
      last_nxt = 3'(blen - 4'h1);
      if (cmd_op == ddc_pkg::CMD_MRS && cmd_bank == 3'h0) begin
        mr0_nxt = cmd_addr; // RL3
      end
      if (cmd_op == ddc_pkg::CMD_WR) begin
        st_nxt  = HS_WLAT;
        cnt_nxt = 3'(ddc_pkg::WR_LAT);
      end else if (cmd_op == ddc_pkg::CMD_RD) begin
        st_nxt   = HS_RWAIT;
        beat_nxt = 3'h0;
      end
    end
    case (st_r)
      HS_WLAT: begin
        if (cnt_r == 3'h0) begin
          st_nxt   = HS_WBURST;
          beat_nxt = 3'h0;
          oe_nxt   = 1'b1;
          {dm_nxt, dq_nxt} = f_data; // RL13
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      HS_WBURST: begin
        if (beat_r == last_r) begin
          st_nxt = HS_IDLE;
        end else begin
          beat_nxt = beat_r + 3'h1;
          oe_nxt   = 1'b1;
          {dm_nxt, dq_nxt} = f_data; // RL13
        end
      end
      HS_RWAIT: begin
        if (lk.dqs_d_oe) begin
          if (beat_r == last_r) begin
            st_nxt = HS_IDLE;
          end else begin
            beat_nxt = beat_r + 3'h1;
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r   <= HS_IDLE;
      cnt_r  <= '0;
      beat_r <= '0;
      last_r <= '0;
      mr0_r  <= ddc_pkg::MR_RST;
      cs_n_r <= 1'b1;
      rcw_r  <= 3'(ddc_pkg::CMD_NOP);
      ba_r   <= '0;
      addr_r <= '0;
      dq_r   <= '0;
      dm_r   <= 1'b0;
      oe_r   <= 1'b0;
      cke_r  <= 1'b0;
      odt_r  <= 1'b0;
      rstn_r <= 1'b0;
      rdv_r  <= 1'b0;
      rdd_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      beat_r <= beat_nxt;
      last_r <= last_nxt;
      mr0_r  <= mr0_nxt;
      cs_n_r <= cs_n_nxt;
      rcw_r  <= rcw_nxt;
      ba_r   <= ba_nxt;
      addr_r <= addr_nxt;
      dq_r   <= dq_nxt;
      dm_r   <= dm_nxt;
      oe_r   <= oe_nxt;
      cke_r  <= cke_req;
      odt_r  <= odt_req;
      rstn_r <= ~reset_req;
      rdv_r  <= lk.dq_d_oe;
      rdd_r  <= lk.dq;
    end
  end
endmodule
`default_nettype wire

// File: sim/ddc_link_checker.sv
// Link checker: timing relations on the DRAM command link
`timescale 1ns/1ns
`default_nettype none
module ddc_link_checker (
  input  wire logic clk,     // Clock
  input  wire logic rst,     // Async reset
  input  wire logic reset_n, // DRAM reset
  input  wire logic cke,     // Clock enable
  input  wire logic cs_n,    // Chip select
  input  wire logic ras_n,   // Command bit
  input  wire logic cas_n,   // Command bit
  input  wire logic we_n,    // Command bit
  input  wire logic odt,     // Termination request
  input  wire logic tdqs,    // Termination strobe
  input  wire logic dq_h_oe, // Controller drives data
  input  wire logic dq_d_oe, // Device drives data
  input  wire logic dqs      // Resolved strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic wr_c;
  logic rd_c;
  assign wr_c = !cs_n && cke && {ras_n, cas_n, we_n} == 3'h4;
  assign rd_c = !cs_n && cke && {ras_n, cas_n, we_n} == 3'h5;
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_wr_lat; wr_c |-> ##[5:6] dq_h_oe; endproperty
  property p_rd_lat; rd_c |-> ##7 dq_d_oe [*4]; endproperty
  property p_wr_len; $rose(dq_h_oe) |-> dq_h_oe [*4]; endproperty
  property p_dqs; (dq_h_oe || dq_d_oe) |-> dqs; endproperty
  property p_bus; !(dq_h_oe && dq_d_oe); endproperty
  property p_one; (wr_c || rd_c) |=> cs_n; endproperty
  property p_term; tdqs |-> $past(odt); endproperty
  property p_cke; !cke && !$past(cke) |-> cs_n; endproperty
  property p_rst; !reset_n |-> cs_n && !dq_h_oe; endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write data not driven in time");
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data not returned in time");
  a_wr_len: assert property (p_wr_len)
    else $error("write burst shorter than four beats");
  a_dqs: assert property (p_dqs)
    else $error("strobe missing on a data beat");
  a_bus: assert property (p_bus)
    else $error("both ends drive the data bus");
  a_one: assert property (p_one)
    else $error("burst command held past one cycle");
  a_term: assert property (p_term)
    else $error("termination strobe without registered odt");
  a_cke: assert property (p_cke)
    else $error("command issued with clock enable low");
  a_rst: assert property (p_rst)
    else $error("activity while device held in reset");
  c_wr: cover property (wr_c);
  c_rd: cover property (rd_c);
  c_tdqs: cover property (tdqs);
  c_sref: cover property (!cke && !cs_n);
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the DRAM command link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic              clk, rst, reset_req, cke_req, odt_req, busy;
  logic              cmd_valid, cmd_ready, wr_valid, wr_ready, wr_mask;
  logic              rd_valid, term_en, tdqs_en;
  ddc_pkg::ddc_cmd_t cmd_op;
  logic [2:0]        cmd_bank, b;
  logic [13:0]       cmd_addr, r;
  logic [3:0]        wr_data, rd_data, c, mem [16], rq[$], eq[$];
  logic [1:0]        pwr_state;
  logic [7:0]        bank_open;
  logic [31:0]       sd, miscompares, n_tests;
  ddc_link_if lk ();
  ddc_ctrl_end u_ddc_ctrl_end (.lk(lk), .clk(clk), .rst(rst),
    .reset_req(reset_req), .cke_req(cke_req), .odt_req(odt_req),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .wr_mask(wr_mask),
    .rd_valid(rd_valid), .rd_data(rd_data));
  ddc_dram_end u_ddc_dram_end (.lk(lk), .clk(clk), .rst(rst),
    .pwr_state(pwr_state), .bank_open(bank_open), .term_en(term_en),
    .tdqs_en(tdqs_en), .busy(busy));
  ddc_link_checker u_ddc_link_checker (.clk(clk), .rst(rst),
    .reset_n(lk.reset_n), .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n),
    .cas_n(lk.cas_n), .we_n(lk.we_n), .odt(lk.odt), .tdqs(lk.tdqs),
    .dq_h_oe(lk.dq_h_oe), .dq_d_oe(lk.dq_d_oe), .dqs(lk.dqs));
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] lf(input logic [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] beat(input logic [3:0] o, n, input logic m);
    beat = m ? o : n;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic cmd(input ddc_pkg::ddc_cmd_t o, input logic [2:0] bk,
                     input logic [13:0] a);
    cmd_op = o;
    cmd_bank = bk;
    cmd_addr = a;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1) tick(1);
    tick(1);
    cmd_valid = 1'h0;
    tick(1);
  endtask
  task automatic push();
    wr_valid = 1'h1;
    while (wr_ready !== 1'h1) tick(1);
    tick(1);
    wr_valid = 1'h0;
    tick(1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests != 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (rd_valid === 1'h1) rq.push_back(rd_data);
  initial begin
    #40000;
    miscompares++;
    results();
  end
  initial begin
    {reset_req, cke_req, odt_req, cmd_valid, wr_valid, wr_mask} = '0;
    {cmd_bank, cmd_addr, wr_data} = '0;
    cmd_op = ddc_pkg::CMD_NOP;
    {miscompares, n_tests} = '0;
    sd = 32'he011;
    rst = 1'h1;
    tick(5);
    rst = 1'h0;
    chk("banks", 32'(bank_open), 32'h0);
    cke_req = 1'h1;
    tick(2);
    cmd(ddc_pkg::CMD_MRS, 3'h0, 14'h0001);
    cmd(ddc_pkg::CMD_MRS, 3'h1, 14'h0004);
    odt_req = 1'h1;
    tick(3);
    chk("term", 32'(term_en), 32'h1);
    sd = lf(sd);
    b = sd[2:0];
    r = sd[16:3];
    for (int t = 0; t < 2; t++) begin
      sd = lf(sd);
      c = sd[3:0];
      rq.delete();
      eq.delete();
      cmd(ddc_pkg::CMD_ACT, b, r);
      chk("open", 32'(bank_open[b]), 32'h1);
      for (int k = 0; k < 16; k++) begin
        sd = lf(sd);
        wr_data = sd[3:0];
        wr_mask = t[0] & sd[4];
        mem[4'(c + k)] = beat(mem[4'(c + k)], wr_data, wr_mask);
        push();
      end
      chk("full", 32'(wr_ready), 32'h0);
      cmd(ddc_pkg::CMD_WR, b, {2'h1, 8'h00, c});
      chk("busy", 32'(busy), 32'h1);
      cmd(ddc_pkg::CMD_WR, b, {2'h1, 8'h00, 4'(c + 8)});
      cmd(ddc_pkg::CMD_RD, b, {2'h1, 8'h00, c});
      cmd(ddc_pkg::CMD_RD, b, {2'h1, 8'h00, 4'(c + 8)});
      cmd(ddc_pkg::CMD_RD, b, {4'h1, 6'h00, c});
      chk("autopre", 32'(bank_open[b]), 32'h0);
      for (int k = 0; k < 20; k++) eq.push_back(mem[4'(c + k % 16)]);
      tick(20);
      chk("idle", 32'(busy), 32'h0);
      chk("beats", 32'(rq.size()), 32'(eq.size()));
      foreach (eq[k]) chk("rdata", 32'(rq[k]), 32'(eq[k]));
      $display("burst test %0d done", t);
    end
    cmd(ddc_pkg::CMD_ACT, 3'h1, 14'h0000);
    cmd(ddc_pkg::CMD_ACT, 3'h2, 14'h0000);
    cmd(ddc_pkg::CMD_PRE, 3'h1, 14'h0000);
    chk("pre_one", 32'(bank_open), 32'h4);
    cke_req = 1'h0;
    tick(4);
    chk("apd", 32'(pwr_state), 32'(ddc_pkg::PWR_APD));
    cke_req = 1'h1;
    tick(4);
    chk("wake", 32'(pwr_state), 32'(ddc_pkg::PWR_NORM));
    cmd(ddc_pkg::CMD_PRE, 3'h5, 14'h0400);
    chk("pre_all", 32'(bank_open), 32'h0);
    cke_req = 1'h0;
    tick(4);
    chk("ppd", 32'(pwr_state), 32'(ddc_pkg::PWR_PPD));
    cke_req = 1'h1;
    tick(4);
    cke_req = 1'h0;
    cmd(ddc_pkg::CMD_REF, 3'h0, 14'h0000);
    chk("sref", 32'(pwr_state), 32'(ddc_pkg::PWR_SREF));
    chk("sref_odt", 32'(term_en), 32'h0);
    cke_req = 1'h1;
    tick(4);
    chk("sr_exit", 32'(pwr_state), 32'(ddc_pkg::PWR_NORM));
    $display("power test done");
    cmd(ddc_pkg::CMD_MRS, 3'h1, 14'h0804);
    tick(2);
    chk("tdqs", 32'({tdqs_en, lk.tdqs}), 32'h3);
    cmd(ddc_pkg::CMD_MRS, 3'h1, 14'h0000);
    tick(2);
    chk("odt_off", 32'(term_en), 32'h0);
    cmd(ddc_pkg::CMD_ACT, 3'h3, 14'h0000);
    reset_req = 1'h1;
    tick(3);
    chk("dram_rst", 32'(bank_open), 32'h0);
    reset_req = 1'h0;
    tick(2);
    $display("mode and reset test done");
    results();
  end
endmodule
`default_nettype wire
